// >>> verilog/bbl_pwm.sv
// module: breathing and blinking led pwm with apb registers
`timescale 1ns/1ns
// Summary of operation
// - period counter wraps at 255, 127 or 63
// - led on while counter below duty
// - control off or reset zeroes counters
// - breathing raises duty by step per interval
// - at upper limit hold, then fall
// - at lower limit hold, then rise
// - symmetric: segment from duty bits 7:5
// - asymmetric: falling bit plus duty 7:6
// - asymmetric: rise segments 0-3, fall 4-7
// - blink: prescaler on slow or main clock
// - blink: advance on prescale zero, reload
// - blink: zero prescale passes every tick
// - blink: period counter always 8 bits
// - blink: frequency clock over 256 times prescale+1
// - blink: duty zero off, maximum on
// - blink ignores ramp and upper settings
// - lower hold lasts lower pause plus one periods
// - control field selects off/breath/blink/on
// - blink clock source one main, zero slow
// - period end loads limits; others only when update set
module bbl_pwm
	import bbl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire bbl_apb_req_t apb_req,
	output bbl_apb_rsp_t apb_rsp,
	output logic led_out
);
	logic [31:0] cfg_r, lim_r, dly_r, step_r, int_r;
	logic [15:0] lim_h_r;
	logic [31:0] dly_h_r, step_h_r, int_h_r;
	logic [31:0] prdata_r;
	logic [12:0] slow_cnt_r;
	logic [7:0] per_r, duty_r;
	logic [11:0] dly_cnt_r;
	logic [3:0] seg_cnt_r;
	bbl_state_t st_r;
	logic led_r;
	bbl_ctl_t ctl;
	logic wr, rd, sync_clr, base_tick, per_tick, per_end, upd_load;
	logic [7:0] per_max, maxv, minv, step_sz;
	logic [2:0] seg;
	logic [3:0] seg_int;
	logic [11:0] hd, ld;

	function automatic logic [3:0] nib(input logic [31:0] v,
		input logic [2:0] i);
		nib = v[{i, 2'b00} +: 4];
	endfunction

	assign ctl = bbl_ctl_t'(cfg_r[BBL_CFG_CTRL_LSB +: 2]);
	assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
	assign sync_clr = (ctl == BBL_CTL_OFF) | cfg_r[BBL_CFG_SYNC_BIT];
	assign maxv = lim_r[15:8];
	assign minv = lim_r[7:0];
	assign hd = dly_r[23:12];
	assign ld = dly_r[11:0];
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = 1'b0;
	assign apb_rsp.prdata = prdata_r;

	always_ff @(posedge clk)
	begin
		if (rst)
			cfg_r <= BBL_CFG_RESET;
		else if (wr && apb_req.paddr == BBL_OFF_CFG)
		begin
			cfg_r <= apb_req.pwdata & 32'h0001_ff3f;
			cfg_r[BBL_CFG_UPD_BIT] <= cfg_r[BBL_CFG_UPD_BIT]
				| apb_req.pwdata[BBL_CFG_UPD_BIT];
			if (apb_req.pwdata[BBL_CFG_RST_BIT])
				cfg_r[BBL_CFG_CTRL_LSB +: 2] <= BBL_CTL_OFF;
		end
		else if (upd_load)
			cfg_r[BBL_CFG_UPD_BIT] <= 1'b0;
	end

	// write-one reset also clears the holding and working copies
	always_ff @(posedge clk)
	begin
		if (rst || (wr && apb_req.paddr == BBL_OFF_CFG
			&& apb_req.pwdata[BBL_CFG_RST_BIT]))
		begin
			lim_h_r <= 16'h0000;
			dly_h_r <= BBL_REG_RESET;
			step_h_r <= BBL_REG_RESET;
			int_h_r <= BBL_REG_RESET;
		end
		else if (wr)
		begin
			case (apb_req.paddr)
				BBL_OFF_LIM: lim_h_r <= apb_req.pwdata[15:0];
				BBL_OFF_DLY: dly_h_r <= apb_req.pwdata & 32'h00ff_ffff;
				BBL_OFF_STEP: step_h_r <= apb_req.pwdata;
				BBL_OFF_INT: int_h_r <= apb_req.pwdata;
				default: ;
			endcase
		end
	end

	assign upd_load = per_end & cfg_r[BBL_CFG_UPD_BIT];
	always_ff @(posedge clk)
	begin
		if (rst || (wr && apb_req.paddr == BBL_OFF_CFG
			&& apb_req.pwdata[BBL_CFG_RST_BIT]))
		begin
			lim_r <= BBL_REG_RESET;
			dly_r <= BBL_REG_RESET;
			step_r <= BBL_REG_RESET;
			int_r <= BBL_REG_RESET;
		end
		else
		begin
			if (per_end)
				lim_r <= {16'h0000, lim_h_r};
			if (upd_load)
			begin
				dly_r <= dly_h_r;
				step_r <= step_h_r;
				int_r <= int_h_r;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			prdata_r <= 32'h0000_0000;
		else if (rd)
		begin
			case (apb_req.paddr)
				BBL_OFF_CFG: prdata_r <= cfg_r;
				BBL_OFF_LIM: prdata_r <= lim_r;
				BBL_OFF_DLY: prdata_r <= dly_r;
				BBL_OFF_STEP: prdata_r <= step_r;
				BBL_OFF_INT: prdata_r <= int_r;
				BBL_OFF_STAT: prdata_r <= {14'h0000, st_r, duty_r, per_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// slow time base derived from the fast clock; no second domain needed
	always_ff @(posedge clk)
	begin
		if (rst || sync_clr || slow_cnt_r == 13'(BBL_SLOW_DIV))
			slow_cnt_r <= 13'h0000;
		else
			slow_cnt_r <= slow_cnt_r + 13'h0001;
	end
	assign base_tick = (ctl == BBL_CTL_BLINK && cfg_r[BBL_CFG_CLKSRC_BIT])
		? 1'b1 : (slow_cnt_r == 13'(BBL_SLOW_DIV));

	always_comb
	begin
		if (ctl == BBL_CTL_BLINK)
			per_max = BBL_MAX8;
		else
		begin
			case (cfg_r[BBL_CFG_SIZE_LSB +: 2])
				2'h1: per_max = BBL_MAX7;
				2'h2: per_max = BBL_MAX6;
				default: per_max = BBL_MAX8;
			endcase
		end
	end

	// blink: prescaler gates the period counter
	assign per_tick = (ctl == BBL_CTL_BLINK)
		? base_tick & (dly_cnt_r == 12'h000) : base_tick;
	assign per_end = per_tick & (per_r >= per_max);

	always_ff @(posedge clk)
	begin
		if (rst || sync_clr)
			per_r <= 8'h00;
		// a smaller size must not leave the counter above its new top
		else if (per_tick || per_r > per_max)
			per_r <= (per_r >= per_max) ? 8'h00 : per_r + 8'h01;
	end

	// duty register bits above the size are ignored by masking the compare
	always_ff @(posedge clk)
	begin
		if (rst)
			led_r <= 1'b0;
		else
		begin
			case (ctl)
				BBL_CTL_ON: led_r <= 1'b1;
				BBL_CTL_BLINK: led_r <= (per_r < minv)
					|| (minv == BBL_MAX8);
				BBL_CTL_BREATH: led_r <= per_r < (duty_r & per_max);
				default: led_r <= 1'b0;
			endcase
		end
	end
	assign led_out = led_r;

	// segment select: symmetric uses 7:5, asymmetric uses direction and 7:6
	assign seg = cfg_r[BBL_CFG_SYM_BIT]
		? {st_r == BBL_ST_FALL, duty_r[7:6]}
		: duty_r[7:5];
	assign step_sz = {4'h0, nib(step_r, seg)};
	assign seg_int = nib(int_r, seg);

	// breathing: segment counter times ramp intervals, delay counter the holds
	always_ff @(posedge clk)
	begin
		if (rst || sync_clr)
		begin
			dly_cnt_r <= 12'h000;
			seg_cnt_r <= 4'h0;
			duty_r <= 8'h00;
			st_r <= BBL_ST_RISE;
		end
		else if (ctl == BBL_CTL_BLINK)
		begin
			if (base_tick)
				dly_cnt_r <= (dly_cnt_r == 12'h000) ? ld
					: dly_cnt_r - 12'h001;
		end
		else if (ctl == BBL_CTL_BREATH && per_end)
		begin
			case (st_r)
				BBL_ST_RISE:
				begin
					if (duty_r >= maxv)
					begin
						st_r <= BBL_ST_HOLD_HI;
						dly_cnt_r <= hd;
					end
					else if (seg_cnt_r >= seg_int)
					begin
						seg_cnt_r <= 4'h0;
						duty_r <= (8'(maxv - duty_r) <= step_sz) ? maxv
							: duty_r + step_sz;
					end
					else
						seg_cnt_r <= seg_cnt_r + 4'h1;
				end
				BBL_ST_HOLD_HI:
				begin
					if (dly_cnt_r == 12'h000)
					begin
						st_r <= BBL_ST_FALL;
						seg_cnt_r <= 4'h0;
					end
					else
						dly_cnt_r <= dly_cnt_r - 12'h001;
				end
				BBL_ST_FALL:
				begin
					if (duty_r <= minv)
					begin
						st_r <= BBL_ST_HOLD_LO;
						dly_cnt_r <= ld;
					end
					else if (seg_cnt_r >= seg_int)
					begin
						seg_cnt_r <= 4'h0;
						duty_r <= (duty_r <= step_sz) ? 8'h00
							: duty_r - step_sz;
					end
					else
						seg_cnt_r <= seg_cnt_r + 4'h1;
				end
				BBL_ST_HOLD_LO:
				begin
					if (dly_cnt_r == 12'h000)
					begin
						st_r <= BBL_ST_RISE;
						seg_cnt_r <= 4'h0;
					end
					else
						dly_cnt_r <= dly_cnt_r - 12'h001;
				end
				default: st_r <= BBL_ST_RISE;
			endcase
		end
	end

	a_off_clears: assert property (@(posedge clk) disable iff (rst)
		ctl == BBL_CTL_OFF |=> per_r == 8'h00 && duty_r == 8'h00)
		else $error("counters not cleared while off");
	a_period_wrap: assert property (@(posedge clk) disable iff (rst)
		per_tick && per_r == per_max && !sync_clr |=> per_r == 8'h00)
		else $error("period counter did not wrap");
	a_period_bound: assert property (@(posedge clk) disable iff (rst)
		ctl == BBL_CTL_BREATH && cfg_r[5:4] == 2'h2 && $stable(cfg_r)
		|=> per_r <= BBL_MAX6)
		else $error("6-bit counter overran");
	a_led_compare: assert property (@(posedge clk) disable iff (rst)
		ctl == BBL_CTL_BREATH && $stable(ctl)
		|=> led_out == ($past(per_r) < ($past(duty_r) & $past(per_max))))
		else $error("led not per compare");
	a_blink_size: assert property (@(posedge clk) disable iff (rst)
		ctl == BBL_CTL_BLINK |-> per_max == BBL_MAX8)
		else $error("blink counter not 8 bits");
	a_blink_gate: assert property (@(posedge clk) disable iff (rst)
		ctl == BBL_CTL_BLINK && dly_cnt_r != 12'h000 && !sync_clr
		|=> $stable(per_r))
		else $error("period advanced during prescale");
	a_force_on: assert property (@(posedge clk) disable iff (rst)
		ctl == BBL_CTL_ON ##1 ctl == BBL_CTL_ON |-> led_out)
		else $error("led not on in always-on");
	a_duty_ceiling: assert property (@(posedge clk) disable iff (rst)
		st_r == BBL_ST_RISE && duty_r <= maxv && $stable(lim_r)
		&& ctl == BBL_CTL_BREATH |=> duty_r <= $past(maxv) || sync_clr)
		else $error("duty stepped past upper limit");
	a_hold_steady: assert property (@(posedge clk) disable iff (rst)
		(st_r == BBL_ST_HOLD_HI || st_r == BBL_ST_HOLD_LO) && !sync_clr
		|=> $stable(duty_r) || sync_clr)
		else $error("duty moved during hold");
	c_reach_top: cover property (@(posedge clk) st_r == BBL_ST_HOLD_HI);
	c_reach_low: cover property (@(posedge clk) st_r == BBL_ST_HOLD_LO);
	c_blink_led: cover property (@(posedge clk)
		ctl == BBL_CTL_BLINK && $rose(led_out));
endmodule // bbl_pwm

// >>> shared/bbl_pkg.sv
// package: register map, fields, reset values and modes of the led pwm
package bbl_pkg;
	localparam logic [7:0] BBL_OFF_CFG = 8'h00;
	localparam logic [7:0] BBL_OFF_LIM = 8'h04;
	localparam logic [7:0] BBL_OFF_DLY = 8'h08;
	localparam logic [7:0] BBL_OFF_STEP = 8'h0c;
	localparam logic [7:0] BBL_OFF_INT = 8'h10;
	localparam logic [7:0] BBL_OFF_STAT = 8'h14;
	localparam int BBL_CFG_CTRL_LSB = 0;
	localparam int BBL_CFG_CLKSRC_BIT = 2;
	localparam int BBL_CFG_SYNC_BIT = 3;
	localparam int BBL_CFG_SIZE_LSB = 4;
	localparam int BBL_CFG_UPD_BIT = 6;
	localparam int BBL_CFG_RST_BIT = 7;
	localparam int BBL_CFG_SYM_BIT = 16;
	localparam logic [31:0] BBL_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] BBL_REG_RESET = 32'h0000_0000;
	localparam logic [7:0] BBL_MAX8 = 8'hff;
	localparam logic [7:0] BBL_MAX7 = 8'h7f;
	localparam logic [7:0] BBL_MAX6 = 8'h3f;
	localparam real BBL_SLOW_HZ = 32768.0;
	localparam real BBL_CLK_MHZ = 250.0;
	// terminal count of the slow tick divider: clock ratio rounded down
	localparam int BBL_SLOW_DIV = int'(BBL_CLK_MHZ * 1.0e6 / BBL_SLOW_HZ - 0.5);
	typedef enum logic [1:0]
	{
		BBL_CTL_OFF = 2'h0,
		BBL_CTL_BREATH = 2'h1,
		BBL_CTL_BLINK = 2'h2,
		BBL_CTL_ON = 2'h3
	} bbl_ctl_t;
	typedef enum logic [1:0]
	{
		BBL_ST_RISE = 2'h0,
		BBL_ST_HOLD_HI = 2'h1,
		BBL_ST_FALL = 2'h3,
		BBL_ST_HOLD_LO = 2'h2
	} bbl_state_t;
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} bbl_apb_req_t;
	typedef struct packed
	{
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} bbl_apb_rsp_t;
endpackage

// >>> tb/bbl_led_load.sv
// led load model: counts clocks with the led lit
`timescale 1ns/1ns
module bbl_led_load
(
	input wire logic clk,
	input wire logic led,
	input wire logic clr,
	output logic [15:0] on_cnt
);
	// brightness seen by the eye is the lit share of a window
	always_ff @(posedge clk)
	begin
		if (clr)
			on_cnt <= 16'h0000;
		else if (led)
			on_cnt <= on_cnt + 16'h0001;
	end
endmodule // bbl_led_load

// >>> tb/test_breathing_blinking_led_pwm.sv
// testbench: apb register access and blink waveform checks
`timescale 1ns/1ns
module test_breathing_blinking_led_pwm
	import bbl_pkg::*;
;
	logic clk;
	logic rst;
	logic clr;
	logic led_out;
	logic [15:0] on_cnt;
	logic [31:0] q;
	bbl_apb_req_t req;
	bbl_apb_rsp_t rsp;
	int n_mismatch;
	int checks_done;

	bbl_pwm i_bbl_pwm (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
		.led_out(led_out));
	bbl_led_load i_bbl_led_load (.clk(clk), .led(led_out), .clr(clr),
		.on_cnt(on_cnt));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task end_sim;
	begin
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask

	// one apb transfer, held until pready is seen at a rising edge
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
	begin
		n = 0;
		@(posedge clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 20);
		q = rsp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 20)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	endtask

	// lit clocks over a window that is a whole number of periods
	task lit(input int cycles, input logic [15:0] exp);
	begin
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (cycles) @(posedge clk);
		#1;
		chk({16'h0000, on_cnt}, {16'h0000, exp});
	end
	endtask

	task reset_values;
		logic [7:0] a[7];
	begin
		a = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
		foreach (a[i])
		begin
			apb(a[i], 1'b0, 32'h0000_0000);
			chk(q, 32'h0000_0000);
		end
		chk({31'h0, led_out}, 32'h0000_0000);
	end
	endtask

	// size and symmetry settings must not change the 8-bit blink
	task blink_fast;
	begin
		apb(BBL_OFF_CFG, 1'b1, 32'h0001_0026);
		apb(BBL_OFF_LIM, 1'b1, 32'h0000_0080);
		repeat (300) @(posedge clk);
		lit(512, 16'h0100);
		apb(BBL_OFF_LIM, 1'b1, 32'h0000_0000);
		repeat (300) @(posedge clk);
		lit(256, 16'h0000);
		apb(BBL_OFF_LIM, 1'b1, 32'h0000_00ff);
		repeat (300) @(posedge clk);
		lit(256, 16'h0100);
	end
	endtask

	// breathing keeps the slow tick even with the main clock selected
	task breath_base;
	begin
		apb(BBL_OFF_CFG, 1'b1, 32'h0000_0000);
		apb(BBL_OFF_CFG, 1'b1, 32'h0000_0025);
		repeat (2 * (BBL_SLOW_DIV + 1) + (BBL_SLOW_DIV + 1) / 2) @(posedge clk);
		apb(BBL_OFF_STAT, 1'b0, 32'h0000_0000);
		chk(q, 32'h0000_0002);
		chk({31'h0, led_out}, 32'h0000_0000);
	end
	endtask

	task blink_prescale;
	begin
		apb(BBL_OFF_LIM, 1'b1, 32'h0000_0040);
		apb(BBL_OFF_DLY, 1'b1, 32'h0000_0001);
		apb(BBL_OFF_CFG, 1'b1, 32'h0000_0046);
		repeat (1100) @(posedge clk);
		apb(BBL_OFF_CFG, 1'b0, 32'h0000_0000);
		chk(q, 32'h0000_0006);
		apb(BBL_OFF_DLY, 1'b0, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		lit(1024, 16'h0100);
	end
	endtask

	task on_then_off;
	begin
		apb(BBL_OFF_CFG, 1'b1, 32'h0000_0003);
		lit(256, 16'h0100);
		apb(BBL_OFF_CFG, 1'b1, 32'h0000_0000);
		lit(256, 16'h0000);
		apb(BBL_OFF_STAT, 1'b0, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(BBL_OFF_CFG, 1'b1, 32'h0000_0082);
		apb(BBL_OFF_DLY, 1'b0, 32'h0000_0000);
		chk(q, 32'h0000_0000);
	end
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end

	initial
	begin
		n_mismatch = 0;
		checks_done = 0;
		rst = 1'b1;
		clr = 1'b0;
		req = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		reset_values();
		blink_fast();
		blink_prescale();
		breath_base();
		on_then_off();
		end_sim();
	end
endmodule // test_breathing_blinking_led_pwm
